// >>> clamp_black_level_control.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - When the pin disable bit is set the multipurpose pin is ignored and reads as low.
// - The two-bit pin function picks clock invert, external clamp, external hold or pixel clock.
// - Each clamp pulse starts DC restore and black-level work if enabled and loads offsets.
// - In internal clamp mode the block makes the clamp pulse itself.
// - In external clamp mode offsets change only on the external pulse's leading edge.
// - In internal clamp mode with no clamp pulse a pending offset may take up to 100 ms to be applied; external clamp mode waits for the pin.
// - The crystal output runs at crystal rate when the select bit is 0, half rate when 1.
// - The crystal output disable bit holds that output low.
// - A 13-bit start value from a 5-bit high and 8-bit low part sets the window start pixel.
// - The clamp width sets the restore pulse length in pixels and leaves averaging alone.
// - A clamp width below 0x02 produces no internal clamp pulse.
// - Black-level compensation runs while its disable bit is 0.
// - The pixel-count field averages 16, 32, 64 or 128 black pixels per line.
// - The loop time constant is 2 to the power 5 plus N lines.
// - Pre and post hold line counts apply only to the internally made hold.
module clamp_black_level_control
  import clamp_pkg::*;
#(
  parameter int UPDATE_TIMEOUT = UPDATE_CYCLES
)(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire clamp_pkg::apb_req_s    apb_req,
  output clamp_pkg::apb_rsp_s         apb_rsp,
  input  wire logic                   hsync_in,
  input  wire logic                   vsync_in,
  input  wire logic                   multi_pin_in,
  input  wire logic                   crystal_clock_in,
  input  wire logic                   pixel_tick,
  output clamp_pkg::video_ctrl_s      video_ctrl
);
  import clamp_pkg::*;

  localparam int UPD_W = $clog2(UPDATE_TIMEOUT + 1);

  typedef struct packed {
    apb_rsp_s         rsp;
    video_ctrl_s      out;
    logic [7:0]       pre_hold;
    logic [7:0]       post_hold;
    logic [7:0]       pin_ctrl;
    logic [7:0]       start_high;
    logic [7:0]       start_low;
    logic [7:0]       clamp_width;
    logic [7:0]       black_cfg;
    logic [7:0]       offset_pend;
    logic [7:0]       control;
    logic [1:0]       hs_sync;
    logic [1:0]       vs_sync;
    logic [1:0]       pin_sync;
    logic [1:0]       xtal_sync;
    logic             hs_prev;
    logic             vs_prev;
    logic             pin_prev;
    logic             xtal_prev;
    logic             xtal_half;
    line_state_e      lstate;
    logic [12:0]      pix_cnt;
    logic [7:0]       clamp_cnt;
    logic [7:0]       avg_cnt;
    logic             pend_valid;
    logic [UPD_W-1:0] upd_cnt;
    logic [11:0]      line_cnt;
    logic [11:0]      frame_lines;
    logic [7:0]       post_cnt;
  } state_s;

  state_s s_q;
  state_s s_d;

  function automatic logic [7:0] avg_pixels(input logic [7:0] cfg);
    avg_pixels = 8'(1 << (AVG_BASE_LOG2 + int'(cfg[BLK_PIX_LO +: 2])));
  endfunction

  function automatic logic [12:0] tc_lines(input logic [7:0] cfg);
    tc_lines = 13'(1 << (TC_BASE_LOG2 + int'(cfg[BLK_TC_LO +: 3])));
  endfunction

  function automatic state_s reset_state();
    state_s r;
    r                       = '0;
    r.pre_hold              = RST_PRE_HOLD;
    r.post_hold             = RST_POST_HOLD;
    r.pin_ctrl              = RST_PIN_CTRL;
    r.start_high            = RST_START;
    r.start_low             = RST_START;
    r.clamp_width           = RST_CLAMP_WIDTH;
    r.black_cfg             = RST_BLACK_CFG;
    r.offset_pend           = RST_OFFSET;
    r.control               = RST_CONTROL;
    r.lstate                = LS_IDLE;
    r.out.black_tc_lines    = tc_lines(RST_BLACK_CFG);
    return r;
  endfunction

  pin_func_e           func;
  logic                pin_eff;
  logic                pin_rise;
  logic                tick;
  logic                hs_trail;
  logic                vs_lead;
  logic                vs_trail;
  logic [12:0]         start_px;
  logic                restore_en;
  logic                black_en;
  logic                int_clamp;
  logic                clamp_evt;
  logic                hold_int;
  logic                access;
  logic [IDX_W-1:0]    idx;
  logic                mapped;
  logic [7:0]          wbyte;

  always_comb
  begin
    s_d        = s_q;
    // First sync stages feed only the second stages
    s_d.hs_sync   = {s_q.hs_sync[0], hsync_in};
    s_d.vs_sync   = {s_q.vs_sync[0], vsync_in};
    s_d.pin_sync  = {s_q.pin_sync[0], multi_pin_in};
    s_d.xtal_sync = {s_q.xtal_sync[0], crystal_clock_in};
    s_d.hs_prev   = s_q.hs_sync[1];
    s_d.vs_prev   = s_q.vs_sync[1];
    s_d.xtal_prev = s_q.xtal_sync[1];

    func       = pin_func_e'(s_q.pin_ctrl[PIN_FUNC_LO +: 2]);
    pin_eff    = s_q.pin_ctrl[PIN_DIS_BIT] ? 1'b0 : s_q.pin_sync[1];
    s_d.pin_prev = pin_eff;
    pin_rise   = pin_eff & ~s_q.pin_prev;
    tick       = (func == PIN_EXT_PIXEL_SAMPLING_CLOCK) ? pin_rise : pixel_tick;
    hs_trail   = s_q.hs_prev & ~s_q.hs_sync[1];
    vs_lead    = ~s_q.vs_prev & s_q.vs_sync[1];
    vs_trail   = s_q.vs_prev & ~s_q.vs_sync[1];
    start_px   = {s_q.start_high[START_HIGH_W-1:0], s_q.start_low};
    restore_en = s_q.control[RESTORE_EN_BIT];
    black_en   = ~s_q.black_cfg[BLK_DIS_BIT];
    int_clamp  = (func != PIN_EXT_CLAMP);
    clamp_evt  = 1'b0;

    // Window sequencer, restarted by every hsync trailing edge
    unique case (s_q.lstate)
      LS_IDLE:
      begin
      end
      LS_COUNT:
      begin
        if (tick)
        begin
          if (s_q.pix_cnt == start_px)
          begin
            s_d.lstate    = LS_OPEN;
            s_d.clamp_cnt = s_q.clamp_width;
            s_d.avg_cnt   = avg_pixels(s_q.black_cfg);
            clamp_evt     = int_clamp;
          end
          else
          begin
            s_d.pix_cnt = s_q.pix_cnt + 13'h0001;
          end
        end
      end
      LS_OPEN:
      begin
        if (tick)
        begin
          if (s_q.clamp_cnt != 8'h00)
          begin
            s_d.clamp_cnt = s_q.clamp_cnt - 8'h01;
          end
          if (s_q.avg_cnt != 8'h00)
          begin
            s_d.avg_cnt = s_q.avg_cnt - 8'h01;
          end
          if (s_q.clamp_cnt <= 8'h01 && s_q.avg_cnt <= 8'h01)
          begin
            s_d.lstate = LS_IDLE;
          end
        end
      end
    endcase
    if (hs_trail)
    begin
      s_d.lstate    = LS_COUNT;
      s_d.pix_cnt   = 13'h0000;
      s_d.clamp_cnt = 8'h00;
      s_d.avg_cnt   = 8'h00;
    end
    if (!int_clamp && pin_rise)
    begin
      clamp_evt = 1'b1;
    end

    // Clamp pulse and averaging window outputs
    if (int_clamp)
    begin
      s_d.out.clamp_pulse = restore_en && (s_q.clamp_width >= CLAMP_MIN)
                            && (s_d.clamp_cnt != 8'h00);
    end
    else
    begin
      s_d.out.clamp_pulse = restore_en & pin_eff;
    end
    s_d.out.black_window   = black_en && (s_d.avg_cnt != 8'h00);
    s_d.out.black_start    = clamp_evt & black_en;
    s_d.out.black_tc_lines = tc_lines(s_q.black_cfg);

    // Offset hand-over; a write in the same cycle stays pending
    s_d.out.offset_load = 1'b0;
    if (clamp_evt)
    begin
      s_d.out.offset_value = s_q.offset_pend;
      s_d.out.offset_load  = 1'b1;
      s_d.pend_valid       = 1'b0;
      s_d.upd_cnt          = '0;
    end
    else if (s_q.pend_valid && int_clamp)
    begin
      // No sync, no internal clamp: apply after the long delay
      if (s_q.upd_cnt == UPD_W'(UPDATE_TIMEOUT - 1))
      begin
        s_d.out.offset_value = s_q.offset_pend;
        s_d.out.offset_load  = 1'b1;
        s_d.pend_valid       = 1'b0;
        s_d.upd_cnt          = '0;
      end
      else
      begin
        s_d.upd_cnt = s_q.upd_cnt + UPD_W'(1);
      end
    end

    // Internal hold around vertical sync
    if (hs_trail)
    begin
      s_d.line_cnt = s_q.line_cnt + 12'h001;
      if (s_q.post_cnt != 8'h00)
      begin
        s_d.post_cnt = s_q.post_cnt - 8'h01;
      end
    end
    if (vs_lead)
    begin
      s_d.frame_lines = s_q.line_cnt;
      s_d.line_cnt    = 12'h000;
    end
    if (vs_trail)
    begin
      s_d.post_cnt = s_q.post_hold;
    end
    hold_int = s_q.vs_sync[1] || (s_q.post_cnt != 8'h00)
               || ((s_q.frame_lines != 12'h000)
                   && ({1'b0, s_q.line_cnt} + {5'h00, s_q.pre_hold}
                       >= {1'b0, s_q.frame_lines}));
    s_d.out.pll_hold = (func == PIN_EXT_HOLD) ? pin_eff : hold_int;
    s_d.out.clock_invert_input       = (func == PIN_CLK_INV) & pin_eff;
    s_d.out.pixel_sampling_clock_sel = (func == PIN_EXT_PIXEL_SAMPLING_CLOCK);

    // Crystal output; half rate toggles on each sampled rising edge
    if (s_q.xtal_sync[1] && !s_q.xtal_prev)
    begin
      s_d.xtal_half = ~s_q.xtal_half;
    end
    if (s_q.pin_ctrl[XTAL_OFF_BIT])
    begin
      s_d.out.crystal_clock_output = 1'b0;
    end
    else if (s_q.pin_ctrl[XTAL_DIV_BIT])
    begin
      s_d.out.crystal_clock_output = s_q.xtal_half;
    end
    else
    begin
      s_d.out.crystal_clock_output = s_q.xtal_sync[1];
    end

    // APB slave, one wait state so read data comes from a flop
    access = apb_req.psel & apb_req.penable;
    idx    = apb_req.paddr[ADDR_W-1:2];
    wbyte  = apb_req.pwdata[REG_W-1:0];
    mapped = (apb_req.paddr[1:0] == 2'b00)
             && ((idx >= IDX_PRE_HOLD && idx <= IDX_BLACK_CFG)
                 || (idx >= IDX_OFFSET && idx <= IDX_STATUS));
    s_d.rsp.pready  = access & ~s_q.rsp.pready;
    s_d.rsp.pslverr = access & ~s_q.rsp.pready & ~mapped;
    s_d.rsp.prdata  = '0;
    if (access && !s_q.rsp.pready && !apb_req.pwrite)
    begin
      unique case (idx)
        IDX_PRE_HOLD:    s_d.rsp.prdata[REG_W-1:0] = s_q.pre_hold;
        IDX_POST_HOLD:   s_d.rsp.prdata[REG_W-1:0] = s_q.post_hold;
        IDX_PIN_CTRL:    s_d.rsp.prdata[REG_W-1:0] = s_q.pin_ctrl;
        IDX_START_HIGH:  s_d.rsp.prdata[REG_W-1:0] = s_q.start_high;
        IDX_START_LOW:   s_d.rsp.prdata[REG_W-1:0] = s_q.start_low;
        IDX_CLAMP_WIDTH: s_d.rsp.prdata[REG_W-1:0] = s_q.clamp_width;
        IDX_BLACK_CFG:   s_d.rsp.prdata[REG_W-1:0] = s_q.black_cfg;
        IDX_OFFSET:      s_d.rsp.prdata[REG_W-1:0] = s_q.offset_pend;
        IDX_CONTROL:     s_d.rsp.prdata[REG_W-1:0] = s_q.control;
        IDX_STATUS:      s_d.rsp.prdata[15:0] = {s_q.out.offset_value, 4'h0,
                                                 s_q.out.pll_hold, s_q.pend_valid,
                                                 s_q.out.clamp_pulse,
                                                 s_q.out.black_window};
        default:         s_d.rsp.prdata = '0;
      endcase
    end
    if (access && s_q.rsp.pready && apb_req.pwrite && mapped)
    begin
      unique case (idx)
        IDX_PRE_HOLD:    s_d.pre_hold    = wbyte;
        IDX_POST_HOLD:   s_d.post_hold   = wbyte;
        IDX_PIN_CTRL:    s_d.pin_ctrl    = wbyte;
        IDX_START_HIGH:  s_d.start_high  = {3'b000, wbyte[START_HIGH_W-1:0]};
        IDX_START_LOW:   s_d.start_low   = wbyte;
        IDX_CLAMP_WIDTH: s_d.clamp_width = wbyte;
        IDX_BLACK_CFG:   s_d.black_cfg   = wbyte;
        IDX_OFFSET:
        begin
          s_d.offset_pend = wbyte;
          s_d.pend_valid  = 1'b1;
          s_d.upd_cnt     = '0;
        end
        IDX_CONTROL:     s_d.control     = wbyte;
        default:         s_d.control     = s_q.control;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= reset_state();
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apb_rsp    = s_q.rsp;
  assign video_ctrl = s_q.out;

endmodule

// >>> clamp_pkg.sv
package clamp_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam int          REG_W             = 8;
  localparam int          IDX_W             = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRE_HOLD    = 6'h11;
  localparam logic [IDX_W-1:0] IDX_POST_HOLD   = 6'h12;
  localparam logic [IDX_W-1:0] IDX_PIN_CTRL    = 6'h13;
  localparam logic [IDX_W-1:0] IDX_START_HIGH  = 6'h14;
  localparam logic [IDX_W-1:0] IDX_START_LOW   = 6'h15;
  localparam logic [IDX_W-1:0] IDX_CLAMP_WIDTH = 6'h16;
  localparam logic [IDX_W-1:0] IDX_BLACK_CFG   = 6'h17;
  localparam logic [IDX_W-1:0] IDX_OFFSET      = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CONTROL     = 6'h21;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 6'h22;

  localparam logic [7:0]  RST_PRE_HOLD      = 8'h08;
  localparam logic [7:0]  RST_POST_HOLD     = 8'h00;
  localparam logic [7:0]  RST_PIN_CTRL      = 8'h00;
  localparam logic [7:0]  RST_START         = 8'h00;
  localparam logic [7:0]  RST_CLAMP_WIDTH   = 8'h10;
  localparam logic [7:0]  RST_BLACK_CFG     = 8'h40;
  localparam logic [7:0]  RST_OFFSET        = 8'h00;
  localparam logic [7:0]  RST_CONTROL       = 8'h01;

  localparam int          PIN_DIS_BIT       = 3;
  localparam int          PIN_FUNC_LO       = 4;
  localparam int          XTAL_DIV_BIT      = 6;
  localparam int          XTAL_OFF_BIT      = 7;
  localparam int          START_HIGH_W      = 5;
  localparam int          BLK_DIS_BIT       = 0;
  localparam int          BLK_PIX_LO        = 2;
  localparam int          BLK_TC_LO         = 4;
  localparam int          RESTORE_EN_BIT    = 0;
  localparam logic [7:0]  CLAMP_MIN         = 8'h02;
  localparam int          AVG_BASE_LOG2     = 4;
  localparam int          TC_BASE_LOG2      = 5;

  localparam int          CLK_KHZ           = 20000;
  localparam int          UPDATE_DELAY_MS   = 100;
  localparam int          UPDATE_CYCLES     = UPDATE_DELAY_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    PIN_CLK_INV    = 2'b00,
    PIN_EXT_CLAMP  = 2'b01,
    PIN_EXT_HOLD   = 2'b10,
    PIN_EXT_PIXEL_SAMPLING_CLOCK = 2'b11
  } pin_func_e;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b001,
    LS_COUNT = 3'b010,
    LS_OPEN  = 3'b100
  } line_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic        clamp_pulse;
    logic        black_window;
    logic        black_start;
    logic        offset_load;
    logic [7:0]  offset_value;
    logic        clock_invert_input;
    logic        pixel_sampling_clock_sel;
    logic        pll_hold;
    logic        crystal_clock_output;
    logic [12:0] black_tc_lines;
  } video_ctrl_s;

endpackage

// >>> clamp_sva.sv
`timescale 1ns/1ps
module clamp_sva
  import clamp_pkg::*;
#(
  parameter int UPDATE_TIMEOUT = UPDATE_CYCLES
)(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire clamp_pkg::apb_req_s    apb_req,
  input wire clamp_pkg::apb_rsp_s    apb_rsp,
  input wire logic                   hsync_in,
  input wire logic                   vsync_in,
  input wire logic                   multi_pin_in,
  input wire logic                   crystal_clock_in,
  input wire logic                   pixel_tick,
  input wire clamp_pkg::video_ctrl_s video_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of pin control, taken at the completing edge only
  logic [7:0] pin_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pin_q <= 8'h00;
    else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
             && apb_req.paddr == {IDX_PIN_CTRL, 2'b00})
      pin_q <= apb_req.pwdata[7:0];
  tc_power_a: assert property (
    $onehot(video_ctrl.black_tc_lines) && video_ctrl.black_tc_lines >= 13'd32)
    else $error("time constant not a power of two");
  pin_excl_a: assert property (
    !(video_ctrl.clock_invert_input && video_ctrl.pixel_sampling_clock_sel))
    else $error("two pin roles at once");
  pix_sel_a: assert property (
    pin_q == $past(pin_q, 2) |->
      video_ctrl.pixel_sampling_clock_sel == (pin_q[5:4] == 2'b11))
    else $error("pixel clock select wrong");
  // Four cycles leave margin; the mask acts after the pin synchroniser
  pin_off_a: assert property (
    pin_q[3] && $past(pin_q, 4) == pin_q |-> !video_ctrl.clock_invert_input
      && !(pin_q[5:4] == 2'b10 && video_ctrl.pll_hold))
    else $error("disabled pin still seen");
  xtal_off_a: assert property (
    pin_q[7] && $past(pin_q[7], 3) |-> !video_ctrl.crystal_clock_output)
    else $error("crystal output not held low");
  load_pulse_a: assert property (
    video_ctrl.offset_load |=> !video_ctrl.offset_load)
    else $error("offset load longer than a cycle");
  offset_hold_a: assert property (
    $changed(video_ctrl.offset_value) |-> video_ctrl.offset_load)
    else $error("offset changed without load");
  start_win_a: assert property (
    video_ctrl.black_start && $past(pin_q[5:4]) != 2'b01 |-> ##[0:3] video_ctrl.black_window)
    else $error("black start without window");
  cover property ($rose(video_ctrl.black_window));
  cover property ($rose(video_ctrl.clamp_pulse));
  cover property (video_ctrl.offset_load);
endmodule

bind clamp_black_level_control clamp_sva #(.UPDATE_TIMEOUT(UPDATE_TIMEOUT)) chk_u (
  .pclk, .presetn, .apb_req, .apb_rsp, .hsync_in, .vsync_in, .multi_pin_in,
  .crystal_clock_in, .pixel_tick, .video_ctrl);

// >>> video_source.sv
`timescale 1ns/1ps
module video_source #(
  parameter int RATE = 2,
  parameter int LINE = 300
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      hsync_in,
  output logic      pixel_tick,
  output logic      crystal_clock_in
);
  // Slow pixel rate so the block must wait on the strobe
  int div_q;
  int pix_q;
  int xdiv_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      div_q <= 0;
      pix_q <= 0;
      xdiv_q <= 0;
      hsync_in <= 1'b0;
      pixel_tick <= 1'b0;
      crystal_clock_in <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == RATE - 1) ? 0 : div_q + 1;
      xdiv_q <= (xdiv_q == 2) ? 0 : xdiv_q + 1;
      crystal_clock_in <= crystal_clock_in ^ (xdiv_q == 2);
      pixel_tick <= run && div_q == RATE - 1;
      // Line timing freezes while stopped
      if (run && div_q == RATE - 1)
      begin
        pix_q <= (pix_q == LINE - 1) ? 0 : pix_q + 1;
        hsync_in <= pix_q < 8;
      end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import clamp_pkg::*;
  typedef struct {
    logic [7:0]  w;
    logic [7:0]  cfg;
    int          c;
    int          b;
    int          s;
    logic [12:0] tc;
  } row_s;
  localparam int RATE = 2;
  localparam int LINE = 300;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        run = 1'b0;
  logic        multi_pin_in = 1'b0;
  logic        vsync_in = 1'b0;
  logic        hsync_in;
  logic        pixel_tick;
  logic        crystal_clock_in;
  logic        p;
  apb_req_s    apb_req = '0;
  apb_rsp_s    apb_rsp;
  video_ctrl_s vc;
  int          fails = 0;
  int          checks = 0;
  int          n;
  int          t;
  logic [31:0] rd;
  logic        err;
  row_s        rows [8] = '{'{8'h04, 8'h40, 4, 16, 1, 13'd512}, '{8'h02, 8'h04, 2, 32, 1, 13'd32},
    '{8'h01, 8'h18, 0, 64, 1, 13'd64}, '{8'h00, 8'h7c, 0, 128, 1, 13'd4096},
    '{8'h03, 8'h30, 3, 16, 1, 13'd256}, '{8'h08, 8'h5c, 8, 128, 1, 13'd1024},
    '{8'h10, 8'h68, 16, 64, 1, 13'd2048}, '{8'hff, 8'h21, 255, 0, 0, 13'd128}};
  logic [5:0]  ridx [9] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h20, 6'h21};
  logic [7:0]  rval [9] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h40, 8'h00, 8'h01};

  always #25 pclk = ~pclk;

  video_source #(.RATE(RATE), .LINE(LINE)) src_u (
    .pclk, .presetn, .run, .hsync_in, .pixel_tick, .crystal_clock_in);
  clamp_black_level_control #(.UPDATE_TIMEOUT(50)) dut_u (
    .pclk, .presetn, .apb_req, .apb_rsp, .hsync_in, .vsync_in, .multi_pin_in,
    .crystal_clock_in, .pixel_tick, .video_ctrl(vc));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up;
    fails++;
    stop_test();
  endtask

  // Setup, then hold everything until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    int i;
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (apb_rsp.pready !== 1'b1 && i < 20);
    if (i >= 20)
      give_up();
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask

  task automatic wait_load;
    n = 0;
    while (vc.offset_load !== 1'b1)
    begin
      @(posedge pclk);
      n++;
      if (n > 3000)
        give_up();
    end
  endtask

  // Observe exactly one line, starting in the sync pulse
  task automatic measure(input row_s r);
    int c;
    int b;
    int s;
    c = 0;
    b = 0;
    s = 0;
    n = 0;
    while (hsync_in !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
      give_up();
    repeat (LINE * RATE)
    begin
      @(posedge pclk);
      c += vc.clamp_pulse;
      b += vc.black_window;
      s += vc.black_start;
    end
    check(c, r.c * RATE);
    check(s, r.s);
    if (r.s > 0)
      check(b, r.b * RATE);
    check(vc.black_tc_lines, r.tc);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    apb(1'b1, IDX_START_LOW, 32'h05);
    foreach (rows[i])
    begin
      apb(1'b1, IDX_CLAMP_WIDTH, {24'h0, rows[i].w});
      apb(1'b1, IDX_BLACK_CFG, {24'h0, rows[i].cfg});
      apb(1'b0, IDX_BLACK_CFG, 32'h0);
      check(rd, {24'h0, rows[i].cfg});
      measure(rows[i]);
      $display("row %0d done", i);
    end
    apb(1'b1, IDX_CLAMP_WIDTH, 32'h04);
    apb(1'b1, IDX_BLACK_CFG, 32'h40);
    apb(1'b1, IDX_CONTROL, 32'h00);
    measure('{8'h04, 8'h40, 0, 16, 1, 13'd512});
    apb(1'b1, IDX_CONTROL, 32'h01);
    apb(1'b1, IDX_OFFSET, 32'h5a);
    wait_load();
    check(vc.offset_value, 8'h5a);
    run <= 1'b0;
    apb(1'b1, IDX_OFFSET, 32'h3c);
    wait_load();
    check(n >= 40 && n <= 60, 1'b1);
    check(vc.offset_value, 8'h3c);
    $display("offset tests done");
    apb(1'b1, IDX_PIN_CTRL, 32'h10);
    run <= 1'b1;
    apb(1'b1, IDX_OFFSET, 32'ha5);
    repeat (2 * LINE * RATE) @(posedge pclk);
    check(vc.offset_value, 8'h3c);
    multi_pin_in <= 1'b1;
    wait_load();
    check(vc.offset_value, 8'ha5);
    repeat (3) @(posedge pclk);
    check(vc.clamp_pulse, 1'b1);
    run <= 1'b0;
    $display("external clamp done");
    for (int f = 0; f < 8; f++)
    begin
      apb(1'b1, IDX_PIN_CTRL, {26'h0, f[1:0], f[2], 3'h0});
      repeat (6) @(posedge pclk);
      check(vc.clock_invert_input, f == 0);
      check(vc.pixel_sampling_clock_sel, f[1:0] == 2'b11);
      if (f[1:0] == 2'b10)
        check(vc.pll_hold, f == 2);
    end
    multi_pin_in <= 1'b0;
    $display("pin modes done");
    // Internal hold follows vsync, then post-hold lines; run is stopped so no line ends
    vsync_in <= 1'b1;
    apb(1'b1, IDX_PIN_CTRL, 32'h00);
    apb(1'b1, IDX_POST_HOLD, 32'h01);
    repeat (6) @(posedge pclk);
    check(vc.pll_hold, 1'b1);
    vsync_in <= 1'b0;
    repeat (6) @(posedge pclk);
    check(vc.pll_hold, 1'b1);
    apb(1'b1, IDX_PIN_CTRL, 32'h20);
    repeat (6) @(posedge pclk);
    check(vc.pll_hold, 1'b0);
    $display("hold tests done");
    // Crystal model rises every 6 cycles
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, IDX_PIN_CTRL, {24'h0, k[1:0], 6'h0});
      repeat (8) @(posedge pclk);
      t = 0;
      p = vc.crystal_clock_output;
      repeat (120)
      begin
        @(posedge pclk);
        t += (vc.crystal_clock_output === 1'b1 && p === 1'b0);
        p = vc.crystal_clock_output;
      end
      n = k[1] ? 0 : (k[0] ? 10 : 20);
      check(t >= n - 1 && t <= n + 1, 1'b1);
    end
    check(vc.crystal_clock_output, 1'b0);
    apb(1'b0, 6'h3f, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("crystal and unmapped done");
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i])
    begin
      apb(1'b0, ridx[i], 32'h0);
      check(rd, {24'h0, rval[i]});
    end
    check(vc.black_tc_lines, 13'd512);
    apb(1'b1, IDX_START_HIGH, 32'hff);
    apb(1'b0, IDX_START_HIGH, 32'h0);
    check(rd, 32'h1f);
    $display("reset test done");
    stop_test();
  end
endmodule
